// File: bench/fpec_top_properties.sv
// Port-level properties of the exception cause block.
// Assumes binding to fpec_top; sees only its ports.
`timescale 1ns/1ps
module fpec_checker
	import fpec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0] pprot,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fpu_done,
	input wire logic fpu_tiny,
	input wire logic fpu_dn_a,
	input wire logic fpu_dn_b,
	input wire logic fpu_dn_c,
	input wire logic special_fp_mode_enable,
	input wire logic irq
);
	logic [3:0] seen_r;
	logic rd_ok;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Last flags reported; the cause bits are not sticky
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seen_r <= 4'h0;
		else if (fpu_done)
			seen_r <= {fpu_tiny, fpu_dn_a, fpu_dn_b, fpu_dn_c};
	end
	assign rd_ok = pready && !pslverr && !pwrite && paddr == FPEC_ADDR_CAUSE;
	user_refused_a: assert property (pready && !pprot[0] |-> pslverr && prdata == 32'h0)
		else $error("user access");
	mode_write_a: assert property (pready && !pslverr && pwrite && paddr == FPEC_ADDR_CAUSE
		|=> special_fp_mode_enable == $past(pwdata[0])) else $error("mode");
	dn_c_a: assert property (rd_ok |-> prdata[28] == seen_r[0]) else $error("dn c");
	dn_b_a: assert property (rd_ok |-> prdata[29] == seen_r[1]) else $error("dn b");
	dn_a_a: assert property (rd_ok |-> prdata[30] == seen_r[2]) else $error("dn a");
	tiny_flag_a: assert property (rd_ok |-> prdata[31] == seen_r[3]) else $error("tiny");
	reserved_zero_a: assert property (rd_ok |-> prdata[27:1] == 27'h0) else $error("rsvd");
	reset_clear_a: assert property (disable iff (1'b0) !presetn |->
		!special_fp_mode_enable && !irq && !pready) else $error("reset");
	cover property (rd_ok && prdata[31]);
	cover property (pready && pslverr);
	cover property ($rose(irq));
endmodule // fpec_checker
bind fpec_top fpec_checker chk_i (.*);

// File: bench/fpec_top_test.sv
// Bench for the exception cause block: APB table, then event cases.
// Assumes fpec_top at 250 MHz, reset held 12 cycles.
`timescale 1ns/1ps
module fpec_top_test
	import fpec_pkg::*;
;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic p; logic [32:0] x;} fpec_row_t;
	logic pclk, presetn, psel, penable, pwrite, fpu_done, fpu_busy;
	logic fpu_tiny, fpu_dn_a, fpu_dn_b, fpu_dn_c, pready, pslverr, special_fp_mode_enable, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] pprot;
	int num_errors = 0;
	int num_checks = 0;
	// Error flag rides on top of expected read data
	fpec_row_t rows [7] = '{'{1, FPEC_ADDR_CAUSE, 32'hFFFF_FFFF, 1, 33'h0},
		'{0, FPEC_ADDR_CAUSE, 0, 1, 33'h1}, '{1, FPEC_ADDR_CAUSE, 0, 0, 33'h1_0000_0000},
		'{0, FPEC_ADDR_CAUSE, 0, 0, 33'h1_0000_0000}, '{0, 12'h00C, 0, 1, 33'h1_0000_0000},
		'{1, FPEC_ADDR_IMASK, 32'hFFFF_FFFF, 1, 33'h0}, '{0, FPEC_ADDR_IMASK, 0, 1, 33'hF000_0000}};
	fpec_top uut (.*);
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic chk(input logic [32:0] g, input logic [32:0] x);
		num_checks++;
		if (g !== x)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	task summarize;
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One APB transfer; an idle cycle follows so psel is never driven twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic p);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pprot <= {2'b00, p};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			num_errors++;
			summarize;
		end
		@(posedge pclk);
	endtask
	initial
	begin
		{psel, penable, pwrite, fpu_done, fpu_busy, fpu_tiny, fpu_dn_a, fpu_dn_b, fpu_dn_c} = 9'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pprot = 3'h0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FPEC_ADDR_CAUSE, 32'h0, 1'b1);
		chk({er, rd}, 33'h0);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d, rows[i].p);
			chk({er, rd}, rows[i].x);
		end
		// Walk each status bit with its own completion
		for (int i = 0; i < 4; i++)
		begin
			{fpu_tiny, fpu_dn_a, fpu_dn_b, fpu_dn_c} <= 4'h1 << i;
			fpu_done <= 1'b1;
			@(posedge pclk);
			fpu_done <= 1'b0;
			@(posedge pclk);
			apb(1'b0, FPEC_ADDR_CAUSE, 32'h0, 1'b1);
			chk({er, rd}, (33'h1000_0000 << i) | 33'h1);
		end
		chk(irq, 1'b1);
		apb(1'b1, FPEC_ADDR_ISTAT, 32'hF000_0000, 1'b1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		// Busy FPU holds off a cause read
		fpu_busy <= 1'b1;
		fork
			apb(1'b0, FPEC_ADDR_CAUSE, 32'h0, 1'b1);
			begin
				repeat (6) @(posedge pclk);
				chk(pready, 1'b0);
				fpu_busy <= 1'b0;
			end
		join
		chk({er, rd}, 33'h8000_0001);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		chk(special_fp_mode_enable, 1'b0);
		summarize;
	end
endmodule // fpec_top_test

// File: shared/fpec_pkg.sv
// Package for the floating-point exception cause block.
// Assumes a 32-bit APB slave port and a core-side completion strobe.
package fpec_pkg;

	// Register byte addresses
	localparam logic [11:0] FPEC_ADDR_CAUSE = 12'h000;
	localparam logic [11:0] FPEC_ADDR_ISTAT = 12'h004;
	localparam logic [11:0] FPEC_ADDR_IMASK = 12'h008;

	// Field positions
	localparam int FPEC_BIT_MODE = 0;
	localparam int FPEC_BIT_DNC = 28;
	localparam int FPEC_BIT_DNB = 29;
	localparam int FPEC_BIT_DNA = 30;
	localparam int FPEC_BIT_TINY = 31;
	localparam int FPEC_NUM_EVT = 4;

	// Reset values and masks
	localparam logic [31:0] FPEC_CAUSE_RESET = 32'h0000_0000;
	localparam logic [31:0] FPEC_IRQ_RESET = 32'h0000_0000;
	localparam logic [31:0] FPEC_CAUSE_WMASK = 32'h0000_0001;
	localparam logic [31:0] FPEC_STAT_MASK = 32'hF000_0000;

	// Access handshake states
	typedef enum logic [1:0]
	{
		FPEC_ST_IDLE,
		FPEC_ST_HOLD,
		FPEC_ST_DONE
	} fpec_state_t;

endpackage

// File: verilog/fpec_flag.sv
// Sticky event flag with write-one-to-clear.
// Assumes set and clear are single-cycle terms in the pclk domain.
`timescale 1ns/1ps
module fpec_flag
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set_evt,
	input wire logic clr_evt,
	output logic flag
);

	// Set beats clear so an event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag <= 1'b0;
		else if (set_evt)
			flag <= 1'b1;
		else if (clr_evt)
			flag <= 1'b0;
	end

endmodule // fpec_flag

// File: verilog/fpec_top.sv
// Floating-point exception cause register with APB access and interrupt.
// Assumes the FPU pulses fpu_done with its flags and raises fpu_busy while
// operations are still in flight.
`timescale 1ns/1ps
module fpec_top
	import fpec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0] pprot,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fpu_done,
	input wire logic fpu_busy,
	input wire logic fpu_tiny,
	input wire logic fpu_dn_a,
	input wire logic fpu_dn_b,
	input wire logic fpu_dn_c,
	output logic special_fp_mode_enable,
	output logic irq
);

	fpec_state_t state_r;
	fpec_state_t state_nxt;
	logic [31:0] fp_exception_cause_reg_r;
	logic mode_r;
	logic [FPEC_NUM_EVT-1:0] cause_stat_r;
	logic [31:0] imask_r;
	logic [31:0] istat;
	logic [31:0] rdata_nxt;
	logic [FPEC_NUM_EVT-1:0] evt_in;
	logic [FPEC_NUM_EVT-1:0] evt_flag;
	logic access;
	logic privileged;
	logic hit_cause;
	logic hit_istat;
	logic hit_imask;
	logic mapped;
	logic err_nxt;
	logic capture;
	logic commit_wr;

	// Address decode; pprot[0] marks a privileged access
	assign access = psel && penable;
	assign privileged = pprot[0];
	assign hit_cause = (paddr == FPEC_ADDR_CAUSE);
	assign hit_istat = (paddr == FPEC_ADDR_ISTAT);
	assign hit_imask = (paddr == FPEC_ADDR_IMASK);
	assign mapped = hit_cause || hit_istat || hit_imask;
	assign err_nxt = !mapped || !privileged;

	// Handshake sequencing; a cause read waits for the FPU to drain
	always_comb
	begin
		state_nxt = state_r;
		capture = 1'b0;
		case (state_r)
			FPEC_ST_IDLE:
			begin
				if (access)
				begin
					if (!pwrite && hit_cause && fpu_busy)
						state_nxt = FPEC_ST_HOLD;
					else
					begin
						state_nxt = FPEC_ST_DONE;
						capture = 1'b1;
					end
				end
			end
			FPEC_ST_HOLD:
			begin
				if (!fpu_busy)
				begin
					state_nxt = FPEC_ST_DONE;
					capture = 1'b1;
				end
			end
			FPEC_ST_DONE:
				state_nxt = FPEC_ST_IDLE;
			default:
				state_nxt = FPEC_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= FPEC_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Write lands only on the edge the master sees pready
	assign commit_wr = (state_r == FPEC_ST_DONE) && access && pwrite && !pslverr;

	// Read mux; reserved and unmapped space read zero
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (privileged)
		begin
			if (hit_cause)
				rdata_nxt = fp_exception_cause_reg_r;
			else if (hit_istat)
				rdata_nxt = istat;
			else if (hit_imask)
				rdata_nxt = imask_r;
		end
	end

	// Answer flops; pready is a one-cycle pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (capture)
		begin
			pready <= 1'b1;
			pslverr <= err_nxt;
			prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Mode bit: software owned, only bit 0 is writable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_r <= FPEC_CAUSE_RESET[FPEC_BIT_MODE];
		else if (commit_wr && hit_cause)
			mode_r <= pwdata[FPEC_BIT_MODE];
	end

	// Whole word assembled here; reserved bits are constant zero, writes ignored
	assign fp_exception_cause_reg_r = {cause_stat_r,
		FPEC_CAUSE_RESET[FPEC_BIT_DNC-1:FPEC_BIT_MODE+1], mode_r};

	// Status bits follow the last completed operation; software cannot write them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cause_stat_r <= FPEC_CAUSE_RESET[FPEC_BIT_TINY:FPEC_BIT_DNC];
		else if (fpu_done)
		begin
			cause_stat_r[0] <= fpu_dn_c;
			cause_stat_r[1] <= fpu_dn_b;
			cause_stat_r[2] <= fpu_dn_a;
			cause_stat_r[3] <= fpu_tiny;
		end
	end

	// Mode output straight from its flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			special_fp_mode_enable <= 1'b0;
		else if (commit_wr && hit_cause)
			special_fp_mode_enable <= pwdata[FPEC_BIT_MODE];
	end

	// Events in status-bit order (28..31)
	assign evt_in = {fpu_tiny, fpu_dn_a, fpu_dn_b, fpu_dn_c} & {FPEC_NUM_EVT{fpu_done}};

	// One sticky cell per event, cleared by writing one
	genvar gi;
	generate
		for (gi = 0; gi < FPEC_NUM_EVT; gi = gi + 1)
		begin : g_evt
			fpec_flag u_flag
			(
				.pclk(pclk),
				.presetn(presetn),
				.set_evt(evt_in[gi]),
				.clr_evt(commit_wr && hit_istat && pwdata[FPEC_BIT_DNC+gi]),
				.flag(evt_flag[gi])
			);
		end
	endgenerate

	assign istat = {evt_flag, 28'h000_0000};

	// Interrupt mask, only event positions stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			imask_r <= FPEC_IRQ_RESET;
		else if (commit_wr && hit_imask)
			imask_r <= pwdata & FPEC_STAT_MASK;
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(istat & imask_r);
	end

endmodule // fpec_top
